// file: design/fpt_pkg.sv
// Package of constants and carrier types for the floating-point transfer decoder.
package fpt_pkg;

	// Register map of the AXI4-Lite slave, byte addresses.
	localparam logic [31:0] FPT_ADDR_CTRL   = 32'h0000_0000;
	localparam logic [31:0] FPT_ADDR_STATUS = 32'h0000_0004;
	localparam logic [31:0] FPT_ADDR_WORDS  = 32'h0000_0008;

	// Control register fields and reset value.
	localparam int          FPT_CTRL_EP_BIT = 0;
	localparam int          FPT_CTRL_EN_BIT = 1;
	localparam logic [1:0]  FPT_CTRL_RESET  = 2'h2;

	// Status register fields.
	localparam int          FPT_STAT_BUSY_BIT = 0;
	localparam int          FPT_STAT_LSB_CNT  = 16;

	// AXI response codes.
	localparam logic [1:0]  FPT_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  FPT_RESP_SLVERR = 2'h2;

	// Instruction field positions.
	localparam int          FPT_BIT_PRE    = 24;
	localparam int          FPT_BIT_UP     = 23;
	localparam int          FPT_BIT_Y      = 22;
	localparam int          FPT_BIT_WB     = 21;
	localparam int          FPT_BIT_LOAD   = 20;
	localparam int          FPT_RN_LSB     = 16;
	localparam int          FPT_BIT_X      = 15;
	localparam int          FPT_FD_LSB     = 12;
	localparam int          FPT_CP_LSB     = 8;

	// Coprocessor field codes for single and multiple transfers.
	localparam logic [3:0]  FPT_CP_SINGLE  = 4'h1;
	localparam logic [3:0]  FPT_CP_MULTI   = 4'h2;

	// Transfer geometry.
	localparam logic [31:0] FPT_WORD_BYTES    = 32'h0000_0004;
	localparam logic [2:0]  FPT_WORDS_PER_REG = 3'h3;
	localparam logic [2:0]  FPT_WORDS_SINGLE  = 3'h1;
	localparam logic [2:0]  FPT_WORDS_DOUBLE  = 3'h2;
	localparam logic [2:0]  FPT_WORDS_EXT     = 3'h3;
	localparam logic [2:0]  FPT_WORDS_EPACKED = 3'h4;

	// Exponent biases and limits of the formats, in 18-bit signed arithmetic.
	localparam logic signed [17:0] FPT_EXT_BIAS = 18'sh0_3FFF;
	localparam logic signed [17:0] FPT_SGL_BIAS = 18'sh0_007F;
	localparam logic signed [17:0] FPT_DBL_BIAS = 18'sh0_03FF;
	localparam logic signed [17:0] FPT_SGL_EMAX = 18'sh0_00FF;
	localparam logic signed [17:0] FPT_DBL_EMAX = 18'sh0_07FF;
	localparam logic [14:0]        FPT_EXT_ESPC = 15'h7FFF;

	// Memory format of a single-register transfer.
	typedef enum logic [1:0] {
		FMT_SINGLE,
		FMT_DOUBLE,
		FMT_EXTENDED,
		FMT_PACKED
	} fpt_fmt_e;

	// Internal register-file value: sign, biased exponent, explicit-integer mantissa.
	typedef struct packed {
		logic        sign;
		logic [14:0] exp;
		logic [63:0] mant;
	} fpt_fpval_s;

	// One word transfer offered to memory.
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        write;
		logic [2:0]  fp_reg;
		logic [1:0]  word_idx;
		logic        last;
	} fpt_mem_req_s;

	// Base register write-back.
	typedef struct packed {
		logic [3:0]  base_reg_index;
		logic [31:0] value;
	} fpt_wb_s;

endpackage

// file: design/fpt_round.sv
// Round-to-nearest-even reduction of a 64-bit mantissa to a narrower width.
`timescale 1ns/1ps
module fpt_round
	import fpt_pkg::*;
#(
	parameter int KEEP = 24
)
(
	input  wire logic [63:0]     mant,
	output logic      [KEEP-1:0] rmant,
	output logic                 carry
);

	logic            lsb;
	logic            guard;
	logic            sticky;
	logic            up;
	logic [KEEP:0]   sum;

	// Ties go to even; bits below the kept width only decide the rounding.
	always_comb
	begin
		lsb    = mant[64-KEEP];
		guard  = mant[63-KEEP];
		sticky = |mant[62-KEEP:0];
		up     = guard & (sticky | lsb);
		sum    = {1'b0, mant[63 -: KEEP]} + {{KEEP{1'b0}}, up};
		carry  = sum[KEEP];
		rmant  = carry ? {1'b1, {(KEEP-1){1'b0}}} : sum[KEEP-1:0];
	end

endmodule

// file: design/fpt_transfer_decode.sv
// Decoder and address generator for floating-point load/store transfer instructions.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module fpt_transfer_decode
	import fpt_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [31:0]  s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [31:0]  s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic         iss_valid,
	output logic              iss_ready,
	input  wire logic [31:0]  iss_instr,
	input  wire logic [31:0]  iss_base,
	input  wire logic         iss_cond_pass,
	output logic [2:0]        rf_rd_index,
	input  wire fpt_fpval_s   rf_rd_value,
	output logic              mem_valid,
	input  wire logic         mem_ready,
	output fpt_mem_req_s      mem_req,
	output logic              wb_valid,
	output fpt_wb_s           wb,
	output logic              done,
	output logic              illegal
);

	typedef enum logic [1:0] {
		S_IDLE,
		S_PREP,
		S_WAIT
	} fpt_state_e;

	// Transfer state.
	fpt_state_e   state_reg, state_next;
	logic [31:0]  addr_reg, addr_next;
	logic [31:0]  wbval_reg, wbval_next;
	logic [3:0]   rn_reg, rn_next;
	logic         wben_reg, wben_next;
	logic         store_reg, store_next;
	logic         multi_reg, multi_next;
	fpt_fmt_e     fmt_reg, fmt_next;
	logic [2:0]   perreg_reg, perreg_next;
	logic [1:0]   regsleft_reg, regsleft_next;
	logic [2:0]   curreg_reg, curreg_next;
	logic [1:0]   widx_reg, widx_next;
	logic         memv_reg, memv_next;
	fpt_mem_req_s req_reg, req_next;
	logic         wbv_reg, wbv_next;
	logic         done_reg, done_next;
	logic         ill_reg, ill_next;
	logic [15:0]  words_reg, words_next;
	logic [15:0]  instrs_reg, instrs_next;

	// Register bus state.
	logic [1:0]   ctrl_reg, ctrl_next;
	logic         awh_reg, awh_next;
	logic [31:0]  awa_reg, awa_next;
	logic         wh_reg, wh_next;
	logic [31:0]  wd_reg, wd_next;
	logic [3:0]   ws_reg, ws_next;
	logic         bv_reg, bv_next;
	logic [1:0]   br_reg, br_next;
	logic         rv_reg, rv_next;
	logic [31:0]  rd_reg, rd_next;
	logic [1:0]   rr_reg, rr_next;

	// Decode helpers.
	logic [3:0]   cp_field;
	logic [1:0]   yx;
	logic [31:0]  off_bytes;
	logic [31:0]  moved_base;
	logic         last_word;
	logic [31:0]  word_data;
	fpt_fmt_e     eff_fmt;

	// Rounding helpers for single and double stores.
	logic [23:0]  rm_s;
	logic         cy_s;
	logic [52:0]  rm_d;
	logic         cy_d;
	logic signed [17:0] e_s;
	logic signed [17:0] e_d;
	logic [31:0]  sgl_word;
	logic [63:0]  dbl_bits;
	logic         is_zero;
	logic         is_spec;

	// Mantissa rounders for the two narrower formats.
	fpt_round #(.KEEP(24)) u_round_s
	(
		.mant  (rf_rd_value.mant),
		.rmant (rm_s),
		.carry (cy_s)
	);

	fpt_round #(.KEEP(53)) u_round_d
	(
		.mant  (rf_rd_value.mant),
		.rmant (rm_d),
		.carry (cy_d)
	);

	// Store conversion: round the mantissa, rebias, flush tiny values to zero and overflow large ones to infinity.
	always_comb
	begin
		is_zero = ~rf_rd_value.mant[63];
		is_spec = (rf_rd_value.exp == FPT_EXT_ESPC);
		e_s = 18'(rf_rd_value.exp) + 18'(cy_s) - FPT_EXT_BIAS + FPT_SGL_BIAS;
		e_d = 18'(rf_rd_value.exp) + 18'(cy_d) - FPT_EXT_BIAS + FPT_DBL_BIAS;
		if (is_spec)
			sgl_word = {rf_rd_value.sign, 8'hFF, rf_rd_value.mant[62:40]};
		else if (is_zero || e_s <= 18'sh0_0000)
			sgl_word = {rf_rd_value.sign, 31'h0000_0000};
		else if (e_s >= FPT_SGL_EMAX)
			sgl_word = {rf_rd_value.sign, 8'hFF, 23'h00_0000};
		else
			sgl_word = {rf_rd_value.sign, e_s[7:0], rm_s[22:0]};
		if (is_spec)
			dbl_bits = {rf_rd_value.sign, 11'h7FF, rf_rd_value.mant[62:11]};
		else if (is_zero || e_d <= 18'sh0_0000)
			dbl_bits = {rf_rd_value.sign, 63'h0000_0000_0000_0000};
		else if (e_d >= FPT_DBL_EMAX)
			dbl_bits = {rf_rd_value.sign, 11'h7FF, 52'h0_0000_0000_0000};
		else
			dbl_bits = {rf_rd_value.sign, e_d[10:0], rm_d[51:0]};
	end

	// Word of store data for the current register and word index.
	always_comb
	begin
		eff_fmt = multi_reg ? FMT_EXTENDED : fmt_reg;
		word_data = 32'h0000_0000;
		unique case (eff_fmt)
			FMT_SINGLE:
				word_data = sgl_word;
			FMT_DOUBLE:
				word_data = (widx_reg == 2'h0) ? dbl_bits[63:32] : dbl_bits[31:0];
			FMT_EXTENDED, FMT_PACKED:
			begin
				unique case (widx_reg)
					2'h0: word_data = {rf_rd_value.sign, 16'h0000, rf_rd_value.exp};
					2'h1: word_data = rf_rd_value.mant[63:32];
					2'h2: word_data = rf_rd_value.mant[31:0];
					2'h3: word_data = 32'h0000_0000;
				endcase
			end
		endcase
	end

	// Instruction decode and the word sequencer.
	always_comb
	begin
		cp_field   = iss_instr[FPT_CP_LSB +: 4];
		yx         = {iss_instr[FPT_BIT_Y], iss_instr[FPT_BIT_X]};
		off_bytes  = {22'h00_0000, iss_instr[7:0], 2'h0};
		moved_base = iss_instr[FPT_BIT_UP] ? iss_base + off_bytes
			: iss_base - off_bytes;
		last_word  = ({1'b0, widx_reg} == perreg_reg - 3'h1) && (regsleft_reg == 2'h0);
		iss_ready  = (state_reg == S_IDLE) && ctrl_reg[FPT_CTRL_EN_BIT];
		state_next = state_reg;
		addr_next = addr_reg;
		wbval_next = wbval_reg;
		rn_next = rn_reg;
		wben_next = wben_reg;
		store_next = store_reg;
		multi_next = multi_reg;
		fmt_next = fmt_reg;
		perreg_next = perreg_reg;
		regsleft_next = regsleft_reg;
		curreg_next = curreg_reg;
		widx_next = widx_reg;
		memv_next = memv_reg;
		req_next = req_reg;
		wbv_next = 1'b0;
		done_next = 1'b0;
		ill_next = 1'b0;
		words_next = words_reg;
		instrs_next = instrs_reg;
		unique case (state_reg)
			S_IDLE:
			begin
				if (iss_valid && iss_ready)
				begin
					if (cp_field != FPT_CP_SINGLE && cp_field != FPT_CP_MULTI)
						ill_next = 1'b1;
					else if (!iss_cond_pass)
						done_next = 1'b1;
					else
					begin
						addr_next = iss_instr[FPT_BIT_PRE] ? moved_base : iss_base;
						wbval_next = moved_base;
						wben_next = iss_instr[FPT_BIT_WB];
						rn_next = iss_instr[FPT_RN_LSB +: 4];
						store_next = ~iss_instr[FPT_BIT_LOAD];
						multi_next = (cp_field == FPT_CP_MULTI);
						fmt_next = fpt_fmt_e'(yx);
						curreg_next = iss_instr[FPT_FD_LSB +: 3];
						widx_next = 2'h0;
						if (cp_field == FPT_CP_MULTI)
						begin
							perreg_next = FPT_WORDS_PER_REG;
							regsleft_next = yx - 2'h1;
						end
						else
						begin
							regsleft_next = 2'h0;
							unique case (yx)
								2'h0: perreg_next = FPT_WORDS_SINGLE;
								2'h1: perreg_next = FPT_WORDS_DOUBLE;
								2'h2: perreg_next = FPT_WORDS_EXT;
								2'h3: perreg_next = ctrl_reg[FPT_CTRL_EP_BIT]
									? FPT_WORDS_EPACKED : FPT_WORDS_EXT;
							endcase
						end
						state_next = S_PREP;
					end
				end
			end
			S_PREP:
			begin
				req_next.addr = addr_reg;
				req_next.wdata = store_reg ? word_data : 32'h0000_0000;
				req_next.write = store_reg;
				req_next.fp_reg = curreg_reg;
				req_next.word_idx = widx_reg;
				req_next.last = last_word;
				memv_next = 1'b1;
				state_next = S_WAIT;
			end
			S_WAIT:
			begin
				if (mem_ready)
				begin
					memv_next = 1'b0;
					words_next = words_reg + 16'h0001;
					addr_next = addr_reg + FPT_WORD_BYTES;
					if (req_reg.last)
					begin
						done_next = 1'b1;
						wbv_next = wben_reg;
						instrs_next = instrs_reg + 16'h0001;
						state_next = S_IDLE;
					end
					else
					begin
						if ({1'b0, widx_reg} == perreg_reg - 3'h1)
						begin
							widx_next = 2'h0;
							curreg_next = curreg_reg + 3'h1;
							regsleft_next = regsleft_reg - 2'h1;
						end
						else
							widx_next = widx_reg + 2'h1;
						state_next = S_PREP;
					end
				end
			end
		endcase
	end

	// AXI4-Lite slave: address and data taken in either order, one response each.
	always_comb
	begin
		s_axi_awready = ~awh_reg & ~bv_reg;
		s_axi_wready = ~wh_reg & ~bv_reg;
		s_axi_arready = ~rv_reg;
		awh_next = awh_reg;
		awa_next = awa_reg;
		wh_next = wh_reg;
		wd_next = wd_reg;
		ws_next = ws_reg;
		bv_next = bv_reg;
		br_next = br_reg;
		rv_next = rv_reg;
		rd_next = rd_reg;
		rr_next = rr_reg;
		ctrl_next = ctrl_reg;
		if (s_axi_awvalid && s_axi_awready)
		begin
			awh_next = 1'b1;
			awa_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			wh_next = 1'b1;
			wd_next = s_axi_wdata;
			ws_next = s_axi_wstrb;
		end
		if (awh_reg && wh_reg)
		begin
			awh_next = 1'b0;
			wh_next = 1'b0;
			bv_next = 1'b1;
			br_next = FPT_RESP_OKAY;
			if (awa_reg[31:2] == FPT_ADDR_CTRL[31:2])
			begin
				if (ws_reg[0])
					ctrl_next = wd_reg[1:0];
			end
			else if (awa_reg[31:2] != FPT_ADDR_STATUS[31:2]
				&& awa_reg[31:2] != FPT_ADDR_WORDS[31:2])
				br_next = FPT_RESP_SLVERR;
		end
		if (bv_reg && s_axi_bready)
			bv_next = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rv_next = 1'b1;
			rr_next = FPT_RESP_OKAY;
			rd_next = 32'h0000_0000;
			if (s_axi_araddr[31:2] == FPT_ADDR_CTRL[31:2])
				rd_next = {30'h0000_0000, ctrl_reg};
			else if (s_axi_araddr[31:2] == FPT_ADDR_STATUS[31:2])
			begin
				rd_next[FPT_STAT_BUSY_BIT] = (state_reg != S_IDLE);
				rd_next[FPT_STAT_LSB_CNT +: 16] = instrs_reg;
			end
			else if (s_axi_araddr[31:2] == FPT_ADDR_WORDS[31:2])
				rd_next = {16'h0000, words_reg};
			else
				rr_next = FPT_RESP_SLVERR;
		end
		else if (rv_reg && s_axi_rready)
			rv_next = 1'b0;
	end

	// State registers.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= S_IDLE;
			addr_reg <= 32'h0000_0000;
			wbval_reg <= 32'h0000_0000;
			rn_reg <= 4'h0;
			wben_reg <= 1'b0;
			store_reg <= 1'b0;
			multi_reg <= 1'b0;
			fmt_reg <= FMT_SINGLE;
			perreg_reg <= 3'h1;
			regsleft_reg <= 2'h0;
			curreg_reg <= 3'h0;
			widx_reg <= 2'h0;
			memv_reg <= 1'b0;
			req_reg <= '0;
			wbv_reg <= 1'b0;
			done_reg <= 1'b0;
			ill_reg <= 1'b0;
			words_reg <= 16'h0000;
			instrs_reg <= 16'h0000;
			ctrl_reg <= FPT_CTRL_RESET;
			awh_reg <= 1'b0;
			awa_reg <= 32'h0000_0000;
			wh_reg <= 1'b0;
			wd_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			bv_reg <= 1'b0;
			br_reg <= FPT_RESP_OKAY;
			rv_reg <= 1'b0;
			rd_reg <= 32'h0000_0000;
			rr_reg <= FPT_RESP_OKAY;
		end
		else
		begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			wbval_reg <= wbval_next;
			rn_reg <= rn_next;
			wben_reg <= wben_next;
			store_reg <= store_next;
			multi_reg <= multi_next;
			fmt_reg <= fmt_next;
			perreg_reg <= perreg_next;
			regsleft_reg <= regsleft_next;
			curreg_reg <= curreg_next;
			widx_reg <= widx_next;
			memv_reg <= memv_next;
			req_reg <= req_next;
			wbv_reg <= wbv_next;
			done_reg <= done_next;
			ill_reg <= ill_next;
			words_reg <= words_next;
			instrs_reg <= instrs_next;
			ctrl_reg <= ctrl_next;
			awh_reg <= awh_next;
			awa_reg <= awa_next;
			wh_reg <= wh_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
			bv_reg <= bv_next;
			br_reg <= br_next;
			rv_reg <= rv_next;
			rd_reg <= rd_next;
			rr_reg <= rr_next;
		end
	end

	// Outputs straight from flip-flops.
	assign rf_rd_index = curreg_reg;
	assign mem_valid = memv_reg;
	assign mem_req = req_reg;
	assign wb_valid = wbv_reg;
	assign wb.base_reg_index = rn_reg;
	assign wb.value = wbval_reg;
	assign done = done_reg;
	assign illegal = ill_reg;
	assign s_axi_bvalid = bv_reg;
	assign s_axi_bresp = br_reg;
	assign s_axi_rvalid = rv_reg;
	assign s_axi_rdata = rd_reg;
	assign s_axi_rresp = rr_reg;

endmodule

// file: dv/fpt_chk.sv
// Concurrent checks on the issue, memory and write-back ports of the transfer decoder.
`timescale 1ns/1ps
module fpt_chk
	import fpt_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         iss_valid,
	input  wire logic         iss_ready,
	input  wire logic [31:0]  iss_instr,
	input  wire logic [31:0]  iss_base,
	input  wire logic         iss_cond_pass,
	input  wire logic         mem_valid,
	input  wire logic         mem_ready,
	input  wire fpt_mem_req_s mem_req,
	input  wire logic         wb_valid,
	input  wire fpt_wb_s      wb,
	input  wire logic         done,
	input  wire logic         illegal
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic        take, hs, mu, pk, lg;
	logic [1:0]  yx;
	logic [3:0]  wn, nw;
	logic [31:0] ci, cb, mb, fa;
	// Decode of the captured instruction: modified base, first address, word count.
	assign take = iss_valid && iss_ready;
	assign hs = mem_valid && mem_ready;
	assign lg = iss_instr[11:8] == FPT_CP_SINGLE || iss_instr[11:8] == FPT_CP_MULTI;
	assign yx = {ci[22], ci[15]};
	assign mu = ci[11:8] == FPT_CP_MULTI;
	assign pk = !mu && yx == 2'h3;
	assign mb = ci[23] ? cb + {22'h0, ci[7:0], 2'h0} : cb - {22'h0, ci[7:0], 2'h0};
	assign fa = ci[24] ? mb : cb;
	assign nw = mu ? (yx == 2'h0 ? 4'hC : 4'(3 * yx)) : 4'(yx) + 4'h1;
	// Captures the accepted instruction and counts its accepted words.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ci <= '0;
			cb <= '0;
			wn <= '0;
		end
		else if (take)
		begin
			ci <= iss_instr;
			cb <= iss_base;
			wn <= '0;
		end
		else if (hs)
			wn <= wn + 4'h1;
	end
	addr_seq_a: assert property (mem_valid |->
		mem_req.addr == fa + {26'h0, wn, 2'h0}) else $error("word address out of sequence");
	reg_order_a: assert property (mem_valid |->
		mem_req.word_idx == (mu ? 2'(wn % 4'h3) : wn[1:0])
		&& mem_req.fp_reg == ci[14:12] + (mu ? 3'(wn / 4'h3) : 3'h0))
		else $error("register order wrong");
	last_word_a: assert property (hs && !pk |->
		mem_req.last == (wn + 4'h1 == nw)) else $error("word count wrong");
	dir_bit_a: assert property (mem_valid |-> mem_req.write == !ci[20])
		else $error("transfer direction wrong");
	start_lat_a: assert property (take && iss_cond_pass && lg |-> ##2 mem_valid)
		else $error("transfer did not start");
	cond_fail_a: assert property (take && !iss_cond_pass && lg |=>
		done && !wb_valid && !mem_valid) else $error("failed condition still acted");
	bad_cp_a: assert property (take && iss_cond_pass && !lg |=>
		illegal && !done && !mem_valid) else $error("unknown coprocessor field accepted");
	end_wb_a: assert property (hs && mem_req.last |=>
		done && wb_valid == ci[21]) else $error("end of transfer wrong");
	wb_val_a: assert property (wb_valid |->
		wb.value == mb && wb.base_reg_index == ci[19:16]) else $error("write-back value wrong");
	req_hold_a: assert property (mem_valid && !mem_ready |=>
		mem_valid && $stable(mem_req)) else $error("request changed before acceptance");
	cover property (hs && mu && mem_req.fp_reg == 3'h0 && ci[14:12] != 3'h0);
	cover property (wb_valid);
	cover property (illegal);
	cover property (take && !iss_cond_pass);
endmodule
bind fpt_transfer_decode fpt_chk fpt_chk_inst (.clk, .arst_n, .iss_valid, .iss_ready,
	.iss_instr, .iss_base, .iss_cond_pass, .mem_valid, .mem_ready, .mem_req, .wb_valid,
	.wb, .done, .illegal);

// file: dv/fpt_mem_model.sv
// Host-side model: register file read port and a memory that accepts words late or early.
`timescale 1ns/1ps
module fpt_mem_model
	import fpt_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [1:0] lag,
	input  wire logic       mem_valid,
	output logic            mem_ready,
	input  wire logic [2:0] rf_rd_index,
	output fpt_fpval_s      rf_rd_value
);
	logic [1:0] wait_cnt;
	// Register i holds sign i[0], unit exponent, and i in the low mantissa bits.
	assign rf_rd_value = {rf_rd_index[0], 15'h3FFF, 32'h8000_0080, 29'h0, rf_rd_index};
	// Accepts an offered word after lag idle cycles; never ready for a word not offered.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wait_cnt <= 2'h0;
			mem_ready <= 1'b0;
		end
		else
		begin
			mem_ready <= mem_valid && !mem_ready && wait_cnt == lag;
			wait_cnt <= (mem_valid && !mem_ready && wait_cnt != lag) ? wait_cnt + 2'h1 : 2'h0;
		end
	end
endmodule

// file: dv/fpt_transfer_decode_tb.sv
// Self-checking bench for the floating-point transfer decoder.
`timescale 1ns/1ps
module fpt_transfer_decode_tb
	import fpt_pkg::*;
;
	logic         clk = 1'b0, arst_n = 1'b0, iss_valid = 1'b0, iss_cond_pass = 1'b0;
	logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ep = 1'b0;
	logic [31:0]  s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [31:0]  iss_instr = '0, iss_base = '0, seed = 32'h0000_0018;
	logic [3:0]   s_axi_wstrb = 4'hF;
	logic [1:0]   lag = 2'h0, s_axi_bresp, s_axi_rresp;
	logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic         iss_ready, mem_valid, mem_ready, wb_valid, done, illegal;
	logic [31:0]  s_axi_rdata;
	logic [2:0]   rf_rd_index;
	fpt_fpval_s   rf_rd_value;
	fpt_mem_req_s mem_req;
	fpt_wb_s      wb;
	logic [79:0]  notes[$];
	int           error_cnt = 0, n_compared = 0, words = 0, instrs = 0;
	fpt_transfer_decode fpt_transfer_decode_inst (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .iss_valid, .iss_ready, .iss_instr, .iss_base,
		.iss_cond_pass, .rf_rd_index, .rf_rd_value, .mem_valid, .mem_ready, .mem_req, .wb_valid,
		.wb, .done, .illegal);
	fpt_mem_model fpt_mem_model_inst (.clk, .arst_n, .lag, .mem_valid, .mem_ready, .rf_rd_index,
		.rf_rd_value);
	// The 40 MHz clock.
	always #12.5 clk = ~clk;
	// Prints the verdict and ends the run.
	task automatic summarize();
		if (error_cnt == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Compares one seen value against its expectation.
	task automatic check(input string nm, input logic [79:0] seen, input logic [79:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Advances one edge; a wait that runs too long ends the run.
	task automatic tick(inout int n);
		@(posedge clk);
		n++;
		if (n > 300)
		begin
			error_cnt++;
			summarize();
		end
	endtask
	// Pseudo-random source.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Stored word k of register r in a format; format 2 is the three-word layout.
	function automatic logic [31:0] wd(input logic [2:0] r, input logic [1:0] f, input int k);
		if (f == 2'h0)
			return {r[0], 8'h7F, 22'h0, r != 3'h0};
		if (f == 2'h1)
			return k == 0 ? {r[0], 11'h3FF, 20'h0} : 32'h1000_0000;
		return k == 0 ? {r[0], 16'h0, 15'h3FFF} : k == 1 ? 32'h8000_0080 : k == 2 ? {29'h0, r} : '0;
	endfunction
	// Register write: address and data offered together, each released when taken.
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		int n = 0;
		notes.push_back({2'h3, 62'h0, r, 14'h0});
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			tick(n);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	// Register read with its expected data and response.
	task automatic axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		int n = 0;
		notes.push_back({2'h3, d, 30'h0, r, 14'h0});
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			tick(n);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask
	// Notes the expected words and end of one instruction, issues it and waits it out.
	task automatic issue(input logic [31:0] ins, input logic [31:0] b, input logic c);
		int n = 0, nw, k;
		logic [1:0] f;
		logic [2:0] r;
		logic [31:0] md, a;
		logic mu;
		f = {ins[22], ins[15]};
		mu = ins[11:8] == FPT_CP_MULTI;
		md = ins[23] ? b + {22'h0, ins[7:0], 2'h0} : b - {22'h0, ins[7:0], 2'h0};
		a = ins[24] ? md : b;
		nw = mu ? (f == 2'h0 ? 12 : 3 * f) : (f == 2'h3 ? 3 + ep : f + 1);
		if (!mu && ins[11:8] != FPT_CP_SINGLE)
			notes.push_back({2'h2, 78'h0});
		else if (!c)
			notes.push_back({2'h1, 78'h0});
		else
		begin
			for (int i = 0; i < nw; i++)
			begin
				k = mu ? i % 3 : i;
				r = mu ? ins[14:12] + 3'(i / 3) : ins[14:12];
				notes.push_back({2'h0, a + 32'(4 * i), ins[20] ? 32'h0 : wd(r, mu ? 2'h2 : f, k),
					r, 2'(k), i == nw - 1, !ins[20], 7'h0});
			end
			words += nw;
			instrs++;
			notes.push_back({2'h1, ins[21] ? md : 32'h0, 32'h0, ins[21],
				ins[21] ? ins[19:16] : 4'h0, 9'h0});
		end
		@(posedge clk);
		iss_instr <= ins;
		iss_base <= b;
		iss_cond_pass <= c;
		iss_valid <= 1'b1;
		do tick(n); while (iss_ready !== 1'b1);
		iss_valid <= 1'b0;
		while (notes.size() != 0) tick(n);
	endtask
	// Takes the oldest expectation off the queue whenever a result appears.
	always @(posedge clk)
	begin
		logic [79:0] got;
		logic ev;
		ev = 1'b1;
		if (mem_valid && mem_ready)
			got = {2'h0, mem_req.addr, mem_req.wdata, mem_req.fp_reg, mem_req.word_idx,
				mem_req.last, mem_req.write, 7'h0};
		else if (done)
			got = {2'h1, wb_valid ? wb.value : 32'h0, 32'h0, wb_valid,
				wb_valid ? wb.base_reg_index : 4'h0, 9'h0};
		else if (illegal)
			got = {2'h2, 78'h0};
		else if (s_axi_bvalid && s_axi_bready)
			got = {2'h3, 62'h0, s_axi_bresp, 14'h0};
		else if (s_axi_rvalid && s_axi_rready)
			got = {2'h3, s_axi_rdata, 30'h0, s_axi_rresp, 14'h0};
		else
			ev = 1'b0;
		if (arst_n && ev)
			check("port result", got, notes.size() != 0 ? notes.pop_front() : 80'h0);
	end
	// Main sequence: registers, then every format and count with random fields.
	initial
	begin
		logic [31:0] x, ins;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		axi_rd(FPT_ADDR_CTRL, {30'h0, FPT_CTRL_RESET}, FPT_RESP_OKAY);
		axi_rd(32'h0000_0010, 32'h0, FPT_RESP_SLVERR);
		axi_wr(32'h0000_0010, 32'h1, FPT_RESP_SLVERR);
		axi_wr(FPT_ADDR_STATUS, 32'hFFFF_FFFF, FPT_RESP_OKAY);
		axi_rd(FPT_ADDR_STATUS, 32'h0, FPT_RESP_OKAY);
		axi_wr(FPT_ADDR_CTRL, 32'h1, FPT_RESP_OKAY);
		check("iss_ready", {79'h0, iss_ready}, 80'h0);
		s_axi_wstrb <= 4'hE;
		axi_wr(FPT_ADDR_CTRL, 32'h2, FPT_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		axi_rd(FPT_ADDR_CTRL, 32'h1, FPT_RESP_OKAY);
		for (int e = 0; e < 2; e++)
		begin
			ep = e[0];
			axi_wr(FPT_ADDR_CTRL, {30'h0, 1'b1, ep}, FPT_RESP_OKAY);
			issue(32'hED2D_6203, 32'h0000_1000, 1'b1);
			issue(32'hED2D_6203, 32'h0000_1000, 1'b0);
			for (int i = 0; i < 40; i++)
			begin
				x = xs();
				ins = x;
				ins[27:25] = 3'h6;
				ins[11:8] = i < 32 ? (i[2] ? FPT_CP_MULTI : FPT_CP_SINGLE) : x[11:8];
				if (i < 32)
				begin
					ins[22] = i[1];
					ins[15] = i[0];
					ins[20] = i[3];
				end
				if (ins[19:16] == 4'hF) ins[19:16] = 4'hE;
				lag <= x[31:30];
				issue(ins, xs(), i < 32 || x[29] || ins[11:8] > 4'h2 || ins[11:8] == 4'h0);
			end
		end
		axi_rd(FPT_ADDR_WORDS, {16'h0, 16'(words)}, FPT_RESP_OKAY);
		axi_rd(FPT_ADDR_STATUS, 32'(instrs) << FPT_STAT_LSB_CNT, FPT_RESP_OKAY);
		summarize();
	end
endmodule
